// [core/swdi_ctrl.sv]
// Mode control, contact classification, alert logic and SPI framing of the switch detector.
`default_nettype none
module swdi_ctrl
    import swdi_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic si,
    output logic so,
    output logic so_oe,
    input wire logic [NUM_SP-1:0] dual_polarity_inputs,
    input wire logic [NUM_SG-1:0] ground_only_inputs,
    input wire logic vdd_present,
    input wire logic thermal_flag,
    input wire logic int_in,
    output logic int_out,
    output logic int_oe,
    input wire logic wake_in,
    output logic wake_out,
    output logic wake_oe,
    input wire logic sleep_request,
    input wire logic int_timer_expired,
    output logic mode_normal,
    output logic alert_level_latched,
    output logic [NUM_SP-1:0] polarity_battery,
    output logic [NUM_IN-1:0] wake_enable,
    output logic [NUM_IN-1:0] wetting_high,
    output logic [NUM_IN-1:0] wetting_timer_enable,
    output logic [NUM_IN-1:0] tristate_enable,
    output logic [AMUX_W-1:0] amux_select,
    output logic calibrate_pulse
);

    ////////////////////////////////////////////////////////////////////////////////
    // Link side: shift registers clocked by the serial clock.

    logic [FRAME_BITS-1:0] rx_shift;
    logic [5:0] fall_cnt;
    logic fall_started;
    logic [5:0] rise_cnt;
    logic rise_started;
    logic so_q;
    logic [FRAME_BITS-1:0] snap;

    // Frame flags are cleared while chip select is high so each frame starts fresh.
    always_ff @(negedge sclk or posedge cs_n)
    begin
        if (cs_n)
            fall_started <= 1'b0;
        else
            fall_started <= 1'b1;
    end

    // Data is sampled on falling edges, MSB first, and the bit count kept.
    always_ff @(negedge sclk)
    begin
        if (!cs_n)
        begin
            rx_shift <= {rx_shift[FRAME_BITS-2:0], si};
            if (!fall_started)
                fall_cnt <= 6'h01;
            else if (fall_cnt != BIT_CNT_MAX)
                fall_cnt <= fall_cnt + 6'h01;
        end
    end

    always_ff @(posedge sclk or posedge cs_n)
    begin
        if (cs_n)
            rise_started <= 1'b0;
        else
            rise_started <= 1'b1;
    end

    // Output changes on rising edges; after a full frame the received bits pass on.
    always_ff @(posedge sclk)
    begin
        if (!cs_n)
        begin
            if (!rise_started)
            begin
                rise_cnt <= 6'h01;
                so_q <= snap[FRAME_BITS-1];
            end
            else
            begin
                if (rise_cnt != BIT_CNT_MAX)
                    rise_cnt <= rise_cnt + 6'h01;
                if (rise_cnt < 6'(FRAME_BITS))
                    so_q <= snap[5'(FRAME_BITS - 1) - rise_cnt[4:0]];
                else
                    so_q <= rx_shift[FRAME_BITS-1];
            end
        end
    end

    assign so = so_q;
    assign so_oe = !cs_n && vdd_present;

    ////////////////////////////////////////////////////////////////////////////////
    // Synchronisers into the core clock.

    logic [2:0] cs_sync;
    logic [2:0] wake_sync;
    logic [2:0] int_sync;
    logic [1:0] vdd_sync;
    logic [1:0] therm_sync;
    logic [NUM_IN-1:0] in_meta;
    logic [NUM_IN-1:0] in_sync;

    // The first stage of each chain feeds only the second stage.
    always_ff @(posedge clk)
    begin
        cs_sync <= {cs_sync[1:0], cs_n};
        wake_sync <= {wake_sync[1:0], wake_in};
        int_sync <= {int_sync[1:0], int_in};
        vdd_sync <= {vdd_sync[0], vdd_present};
        therm_sync <= {therm_sync[0], thermal_flag};
        in_meta <= {ground_only_inputs, dual_polarity_inputs};
        in_sync <= in_meta;
    end

    logic cs_high;
    logic cs_fall;
    logic cs_rise;
    logic wake_fall;
    logic int_fall;
    logic vdd_on;
    assign cs_high = cs_sync[1];
    assign cs_fall = !cs_sync[1] && cs_sync[2];
    assign cs_rise = cs_sync[1] && !cs_sync[2];
    assign wake_fall = !wake_sync[1] && wake_sync[2];
    assign int_fall = !int_sync[1] && int_sync[2];
    assign vdd_on = vdd_sync[1];

    ////////////////////////////////////////////////////////////////////////////////
    // Contact classification and change detection.

    logic [NUM_IN-1:0] closed;
    logic [NUM_IN-1:0] closed_prev;
    logic [NUM_IN-1:0] en_change;
    logic any_change;

    // Comparator level is one above 4.0 V.
    genvar gi;
    generate
        for (gi = 0; gi < NUM_IN; gi = gi + 1)
        begin : g_class
            if (gi < NUM_SP)
            begin : g_sp
                assign closed[gi] = in_sync[gi] ~^ polarity_battery[gi];
            end
            else
            begin : g_sg
                assign closed[gi] = !in_sync[gi];
            end
        end
    endgenerate

    // Following the live state through reset avoids a false change when reset ends.
    always_ff @(posedge clk)
    begin
        closed_prev <= closed;
    end

    assign en_change = (closed ^ closed_prev) & wake_enable;
    assign any_change = |en_change;

    ////////////////////////////////////////////////////////////////////////////////
    // Operating mode.

    swdi_mode_t mode;
    swdi_mode_t next_mode;

    always_comb
    begin
        next_mode = mode;
        unique case (mode)
            SWDI_NORMAL:
            begin
                if (sleep_request)
                    next_mode = SWDI_SLEEP;
            end
            SWDI_SLEEP:
            begin
                // Supply loss alone never moves the state.
                if (any_change || int_timer_expired)
                    next_mode = SWDI_NORMAL;
                else if (wake_fall && (!vdd_on || int_sync[1]))
                    next_mode = SWDI_NORMAL;
                else if (vdd_on && ((int_fall && wake_sync[1]) || cs_fall))
                    next_mode = SWDI_NORMAL;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
            mode <= SWDI_NORMAL;
        else
            mode <= next_mode;
    end

    assign mode_normal = (mode == SWDI_NORMAL);
    assign wake_out = 1'b0;
    assign wake_oe = (mode == SWDI_NORMAL);

    ////////////////////////////////////////////////////////////////////////////////
    // Alert output.

    logic alert;
    logic chg_in_frame;

    // A change during the frame keeps the alert past the chip select rise.
    always_ff @(posedge clk)
    begin
        if (!resetn)
            chg_in_frame <= 1'b0;
        else if (cs_fall)
            chg_in_frame <= any_change;
        else if (!cs_high && any_change)
            chg_in_frame <= 1'b1;
    end

    // New changes in normal mode win over the clear at chip select rise.
    always_ff @(posedge clk)
    begin
        if (!resetn)
            alert <= 1'b0;
        else if (any_change && mode == SWDI_NORMAL)
            alert <= 1'b1;
        else if (cs_rise && !chg_in_frame)
            alert <= 1'b0;
    end

    assign int_out = 1'b0;
    assign int_oe = alert;

    ////////////////////////////////////////////////////////////////////////////////
    // Response snapshot.

    // Snapshot follows live state while deselected and freezes once the select falls.
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            snap <= '0;
            alert_level_latched <= 1'b1;
        end
        else if (cs_high)
            snap <= {alert, therm_sync[1], closed};
        if (resetn && cs_fall)
            alert_level_latched <= int_sync[1];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Command decode and configuration.

    logic take_cmd;
    logic [7:0] cmd;
    logic [NUM_IN-1:0] pay;
    assign cmd = rx_shift[CMD_MSB:CMD_LSB];
    assign pay = rx_shift[NUM_IN-1:0];
    assign take_cmd = cs_rise && mode == SWDI_NORMAL && vdd_on
        && (fall_cnt == 6'(FRAME_BITS) || fall_cnt == 6'(CHAIN_BITS));

    always_ff @(posedge clk)
    begin
        if (!resetn || (take_cmd && cmd == CMD_RESET))
        begin
            polarity_battery <= RST_POLARITY;
            wake_enable <= RST_WAKE_EN;
            wetting_high <= RST_METAL;
            wetting_timer_enable <= RST_TIMER_EN;
            tristate_enable <= RST_TRISTATE;
            amux_select <= RST_AMUX;
        end
        else if (take_cmd)
        begin
            unique case (cmd)
                CMD_SETTINGS: polarity_battery <= pay[NUM_SP-1:0];
                CMD_WAKE_SP: wake_enable[NUM_SP-1:0] <= pay[NUM_SP-1:0];
                CMD_WAKE_SG: wake_enable[NUM_IN-1:NUM_SP] <= pay[NUM_SG-1:0];
                CMD_METAL_SP: wetting_high[NUM_SP-1:0] <= pay[NUM_SP-1:0];
                CMD_METAL_SG: wetting_high[NUM_IN-1:NUM_SP] <= pay[NUM_SG-1:0];
                CMD_TIMER_SP: wetting_timer_enable[NUM_SP-1:0] <= pay[NUM_SP-1:0];
                CMD_TIMER_SG: wetting_timer_enable[NUM_IN-1:NUM_SP] <= pay[NUM_SG-1:0];
                CMD_TRI_SP: tristate_enable[NUM_SP-1:0] <= pay[NUM_SP-1:0];
                CMD_TRI_SG: tristate_enable[NUM_IN-1:NUM_SP] <= pay[NUM_SG-1:0];
                CMD_ANALOG: amux_select <= pay[AMUX_W-1:0];
                default:
                begin
                end
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
            calibrate_pulse <= 1'b0;
        else
            calibrate_pulse <= take_cmd && cmd == CMD_CALIB;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    chk_wake_pin_drive: assert property (@(posedge clk) disable iff (!resetn)
        (mode == SWDI_SLEEP && !any_change && !int_timer_expired && !wake_fall
            && !int_fall && !cs_fall) |=> !wake_oe)
        else $error("wake pin driven in sleep without a wake event");

    chk_alert_on_change: assert property (@(posedge clk) disable iff (!resetn)
        (mode == SWDI_NORMAL && any_change) |=> int_oe [*2])
        else $error("alert not raised on enabled change");

    chk_alert_release: assert property (@(posedge clk) disable iff (!resetn)
        (cs_rise && !chg_in_frame && !any_change && alert) |=> !int_oe)
        else $error("alert not released at select rise");

    chk_alert_kept: assert property (@(posedge clk) disable iff (!resetn)
        (cs_rise && chg_in_frame && alert) |=> int_oe)
        else $error("alert released despite change in frame");

    chk_no_write_gate: assert property (@(posedge clk) disable iff (!resetn)
        (cs_rise && (mode == SWDI_SLEEP || !vdd_on)) |=> $stable(wake_enable))
        else $error("register written outside normal mode");

    chk_wake_edge: assert property (@(posedge clk) disable iff (!resetn)
        (mode == SWDI_SLEEP && wake_fall && !vdd_on) |=> ##[0:1] mode_normal)
        else $error("wake edge did not wake device");

    chk_spi_no_vdd: assert property (@(posedge clk) disable iff (!resetn)
        (!vdd_present) |-> !so_oe)
        else $error("serial output driven without logic supply");

    chk_snap_frozen: assert property (@(posedge clk) disable iff (!resetn)
        (!cs_high && !$past(cs_high)) |-> $stable(snap))
        else $error("response changed during frame");

    chk_reset_mode: assert property (@(posedge clk)
        (!resetn) |=> (mode == SWDI_NORMAL && polarity_battery == RST_POLARITY))
        else $error("reset did not restore normal mode and defaults");

endmodule : swdi_ctrl
`default_nettype wire

// [shared/swdi_pkg.sv]
// Constants and types shared by the switch-detect wake and alert control block.
`default_nettype none
package swdi_pkg;
    localparam int NUM_SP = 8;
    localparam int NUM_SG = 14;
    localparam int NUM_IN = 22;
    localparam int FRAME_BITS = 24;
    localparam int CHAIN_BITS = 48;
    localparam logic [5:0] BIT_CNT_MAX = 6'h3f;
    // Response layout.
    localparam int RESP_INT_POS = 23;
    localparam int RESP_THERM_POS = 22;
    localparam int RESP_SG_LSB = 8;
    localparam int RESP_SP_LSB = 0;
    // Command byte field and payload.
    localparam int CMD_MSB = 23;
    localparam int CMD_LSB = 16;
    localparam int AMUX_W = 5;
    localparam logic [7:0] CMD_SETTINGS = 8'h01;
    localparam logic [7:0] CMD_WAKE_SP = 8'h02;
    localparam logic [7:0] CMD_WAKE_SG = 8'h03;
    localparam logic [7:0] CMD_METAL_SP = 8'h04;
    localparam logic [7:0] CMD_METAL_SG = 8'h05;
    localparam logic [7:0] CMD_TIMER_SP = 8'h07;
    localparam logic [7:0] CMD_TIMER_SG = 8'h08;
    localparam logic [7:0] CMD_TRI_SP = 8'h09;
    localparam logic [7:0] CMD_TRI_SG = 8'h0a;
    localparam logic [7:0] CMD_ANALOG = 8'h0b;
    localparam logic [7:0] CMD_CALIB = 8'h0c;
    localparam logic [7:0] CMD_RESET = 8'h7f;
    // Values after power-on reset or reset command.
    localparam logic [7:0] RST_POLARITY = 8'hff;
    localparam logic [21:0] RST_WAKE_EN = 22'h3fffff;
    localparam logic [21:0] RST_METAL = 22'h3fffff;
    localparam logic [21:0] RST_TIMER_EN = 22'h3fffff;
    localparam logic [21:0] RST_TRISTATE = 22'h3fffff;
    localparam logic [4:0] RST_AMUX = 5'h00;
    typedef enum logic {
        SWDI_NORMAL = 1'b0,
        SWDI_SLEEP = 1'b1
    } swdi_mode_t;
endpackage : swdi_pkg
`default_nettype wire

// [tb/swdi_host.sv]
// Host serial master model that frames transfers to the switch detector.
`default_nettype none
module swdi_host
(
    output var logic sclk,
    output var logic cs_n,
    output var logic si,
    input wire logic so,
    input wire logic so_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
    end
    // Clocks n bits of w out MSB first at 160 ns per bit; the clock rests low outside frames.
    task automatic xfer(input logic [47:0] w, input int n, output logic [47:0] q);
        q = 48'h0;
        cs_n = 1'b0;
        #500;
        for (int i = n - 1; i >= 0; i--)
        begin
            sclk = 1'b1;
            si = w[i];
            #80;
            q = {q[46:0], so};
            sclk = 1'b0;
            #80;
        end
        cs_n = 1'b1;
        si = ~si;
        #500;
    endtask : xfer
endmodule : swdi_host
`default_nettype wire

// [tb/test_switch_detect_wake_irq_ctrl.sv]
// Self-checking bench for the switch-detect wake and alert control block.
`default_nettype none
module test_switch_detect_wake_irq_ctrl
    import swdi_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic sclk, cs_n, si, so, so_oe, int_oe, wake_oe, mode_normal, alert_level_latched;
    logic vdd_present = 1'b1;
    logic thermal_flag = 1'b0;
    logic xint = 1'b0;
    logic xwake = 1'b0;
    logic sleep_request = 1'b0;
    logic int_timer_expired = 1'b0;
    logic calibrate_pulse;
    logic cal_seen = 1'b0;
    logic [NUM_SP-1:0] sp = 8'h00;
    logic [NUM_SP-1:0] polarity_battery;
    logic [NUM_SG-1:0] sg = 14'h3ffe;
    logic [NUM_IN-1:0] wake_enable, wetting_high, wetting_timer_enable, tristate_enable;
    logic [AMUX_W-1:0] amux_select;
    logic [47:0] r;
    int n_fail = 0;
    int checks_done = 0;
    int cyc = 0;
    // Both open-drain wires carry pullups; another party may pull them low.
    wire int_in = ~(int_oe | xint);
    wire wake_in = ~(wake_oe | xwake);
    swdi_host host (.sclk, .cs_n, .si, .so, .so_oe);
    swdi_ctrl dut (.clk, .resetn, .sclk, .cs_n, .si, .so, .so_oe,
        .dual_polarity_inputs(sp), .ground_only_inputs(sg), .vdd_present, .thermal_flag,
        .int_in, .int_out(), .int_oe, .wake_in, .wake_out(), .wake_oe, .sleep_request,
        .int_timer_expired, .mode_normal, .alert_level_latched, .polarity_battery,
        .wake_enable, .wetting_high, .wetting_timer_enable, .tristate_enable,
        .amux_select, .calibrate_pulse);
    ////////////////////////////////////////////////////////////////////////////////////
    always #50 clk = ~clk;
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (calibrate_pulse === 1'b1)
            cal_seen <= 1'b1;
        if (cyc == 20000)
        begin
            n_fail++;
            test_done;
        end
    end
    always @(negedge sclk)
        if (vdd_present && resetn)
            chk("so_oe frame", 1'b1, so_oe);
    task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
        checks_done++;
        if (g !== e)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic test_done;
        $display("Checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done
    task automatic ticks(input int n);
        repeat (n) @(negedge clk);
    endtask : ticks
    task automatic hx(input logic [47:0] w, input int n);
        host.xfer(w, n, r);
        ticks(1);
    endtask : hx
    task automatic send(input logic [7:0] c, input logic [15:0] p);
        hx({24'h0, c, p}, 24);
    endtask : send
    function automatic logic [23:0] resp(input logic a, input logic [7:0] s);
        resp = {a, thermal_flag, ~sg, s};
    endfunction : resp
    function automatic logic [21:0] cfg(input int k);
        case (k)
            0: cfg = wake_enable;
            1: cfg = wetting_high;
            2: cfg = wetting_timer_enable;
            default: cfg = tristate_enable;
        endcase
    endfunction : cfg
    task automatic mchk(input string nm, input logic e);
        ticks(6);
        chk(nm, e, mode_normal);
        chk("wake_oe", e, wake_oe);
    endtask : mchk
    task automatic nap;
        sleep_request = 1'b1;
        ticks(1);
        sleep_request = 1'b0;
        mchk("sleep", 1'b0);
    endtask : nap
    task automatic defaults;
        chk("polarity", 8'hff, polarity_battery);
        for (int k = 0; k < 4; k++)
            chk("cfg", 22'h3fffff, cfg(k));
        chk("amux", 5'h00, amux_select);
    endtask : defaults
    ////////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        mchk("mode", 1'b1);
        chk("int_oe", 1'b0, int_oe);
        chk("so_oe idle", 1'b0, so_oe);
        defaults;
        $display("t_reset done");
    endtask : t_reset
    task automatic t_alert;
        sp = 8'h3c;
        sg = 14'h0f0f;
        thermal_flag = 1'b1;
        ticks(6);
        chk("alert set", 1'b1, int_oe);
        fork
            hx(48'h0, 24);
            begin
                ticks(15);
                sp = 8'h3d;
            end
        join
        chk("response", resp(1'b1, 8'h3c), r[23:0]);
        chk("latched", 1'b0, alert_level_latched);
        chk("alert held", 1'b1, int_oe);
        send(8'h00, 16'h0);
        chk("response 2", resp(1'b1, 8'h3d), r[23:0]);
        chk("alert clear", 1'b0, int_oe);
        chk("so_oe", 1'b0, so_oe);
        $display("t_alert done");
    endtask : t_alert
    task automatic t_share;
        send(CMD_WAKE_SP, 16'h0000);
        chk("wake sp", 22'h3fff00, wake_enable);
        sp = 8'h00;
        ticks(6);
        chk("disabled", 1'b0, int_oe);
        xint = 1'b1;
        send(8'h00, 16'h0);
        xint = 1'b0;
        chk("other flag", resp(1'b0, 8'h00), r[23:0]);
        chk("other pin", 1'b0, alert_level_latched);
        $display("t_share done");
    endtask : t_share
    task automatic t_cmds;
        logic [7:0] c;
        send(CMD_SETTINGS, 16'h00aa);
        chk("polarity", 8'haa, polarity_battery);
        for (int k = 0; k < 4; k++)
        begin
            c = k == 0 ? CMD_WAKE_SP : k == 1 ? CMD_METAL_SP : k == 2 ? CMD_TIMER_SP : CMD_TRI_SP;
            send(c, 16'h00a5);
            send(c + 8'h01, 16'h1234);
            chk("cfg", {14'h1234, 8'ha5}, cfg(k));
        end
        send(CMD_ANALOG, 16'h0015);
        chk("amux", 5'h15, amux_select);
        chk("cal idle", 1'b0, cal_seen);
        send(CMD_CALIB, 16'h0);
        chk("cal", 1'b1, cal_seen);
        send(CMD_RESET, 16'h0);
        defaults;
        send(8'h00, 16'h0);
        $display("t_cmds done");
    endtask : t_cmds
    task automatic t_refuse;
        hx({24'h0, CMD_ANALOG, 16'h0011}, 23);
        chk("short frame", 5'h00, amux_select);
        hx({24'h5a5a5a, CMD_ANALOG, 16'h0012}, 48);
        chk("chain", 5'h12, amux_select);
        chk("pass", 24'h5a5a5a, r[23:0]);
        chk("chain resp", resp(1'b0, 8'h00), r[47:24]);
        chk("latched idle", 1'b1, alert_level_latched);
        vdd_present = 1'b0;
        send(CMD_ANALOG, 16'h0013);
        chk("no supply", 5'h12, amux_select);
        mchk("keep normal", 1'b1);
        vdd_present = 1'b1;
        $display("t_refuse done");
    endtask : t_refuse
    task automatic t_modes;
        nap;
        vdd_present = 1'b0;
        mchk("keep sleep", 1'b0);
        send(CMD_ANALOG, 16'h0014);
        mchk("no cs wake", 1'b0);
        chk("sleep write", 5'h12, amux_select);
        xint = 1'b1;
        mchk("no int wake", 1'b0);
        xint = 1'b0;
        xwake = 1'b1;
        mchk("wake pin", 1'b1);
        xwake = 1'b0;
        vdd_present = 1'b1;
        nap;
        xint = 1'b1;
        mchk("int wake", 1'b1);
        nap;
        xwake = 1'b1;
        mchk("int low", 1'b0);
        xint = 1'b0;
        xwake = 1'b0;
        ticks(2);
        xwake = 1'b1;
        mchk("wake pin 2", 1'b1);
        xwake = 1'b0;
        nap;
        int_timer_expired = 1'b1;
        ticks(1);
        int_timer_expired = 1'b0;
        mchk("timer", 1'b1);
        nap;
        send(8'h00, 16'h0);
        mchk("cs wake", 1'b1);
        nap;
        sp = 8'h01;
        mchk("switch wake", 1'b1);
        $display("t_modes done");
    endtask : t_modes
    initial
    begin
        ticks(6);
        resetn = 1'b1;
        ticks(4);
        t_reset;
        t_alert;
        t_share;
        t_cmds;
        t_refuse;
        t_modes;
        test_done;
    end
endmodule : test_switch_detect_wake_irq_ctrl
`default_nettype wire
